// *** design/magnet_seq_map.svh ***
// constants for the ramp and switch sequencer
`ifndef MAGNET_SEQ_MAP_SVH
`define MAGNET_SEQ_MAP_SVH
`define CLK_HZ 250000000
`define MS_PER_S 1000
`define HEAT_TIME_MIN 12'h005
`define HEAT_TIME_MAX 12'h078
`define HEAT_TIME_DEFAULT 12'h014
`define COOL_TIME_MIN 12'h005
`define COOL_TIME_MAX 12'hE10
`define COOL_TIME_DEFAULT 12'h014
`define SETTLE_S 12'h005
`define SHOW_S 12'h003
`define SW_RATE_DEFAULT 16'h000A
`define AVG_LIMIT_NV 32'h0007A120
`define VAR_HYST 48'h000000000006
`define COOL_GAIN_DEFAULT 8'h00
`define STAT_SHIFT 4
`endif

// *** design/magnet_seq_pkg.sv ***
// types shared by the sequencer modules
`default_nettype none
package magnet_seq_pkg;
	typedef enum logic [1:0] {OFF_COOLED, HEATING, ON_HEATED, COOLING} heat_state_type;
	typedef enum logic [1:0] {RAMP_PAUSED, RAMP_ACTIVE, RAMP_HOLD, RAMP_BLANK} ramp_mode_type;
endpackage : magnet_seq_pkg
`default_nettype wire

// *** design/volt_stats_if.sv ***
// magnet voltage samples in, running statistics out
`default_nettype none
interface volt_stats_if;
	logic signed [31:0] sample;
	logic valid;
	logic signed [31:0] average;
	logic [47:0] variance;
	modport producer(input sample, input valid, output average, output variance);
	modport consumer(output sample, output valid, input average, input variance);
endinterface : volt_stats_if
`default_nettype wire

// *** design/second_counter.sv ***
// whole-unit countdown with its own prescaler
`default_nettype none
module second_counter #(
	parameter int CYC = 250000000,
	parameter int W = 12
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic load,
	input wire logic [W-1:0] loadValue,
	output logic [W-1:0] count,
	output logic done
);
	logic [31:0] pre_reg, pre_next;
	logic [W-1:0] cnt_reg, cnt_next;
	logic done_reg, done_next;

	always_comb
	begin
		pre_next = pre_reg;
		cnt_next = cnt_reg;
		done_next = 1'b0;
		if (load)
		begin
			pre_next = 32'h0;
			cnt_next = loadValue;
		end
		else if (cnt_reg != '0)
		begin
			if (pre_reg == 32'(CYC - 1))
			begin
				pre_next = 32'h0;
				cnt_next = cnt_reg - 1'b1;
				done_next = (cnt_reg == W'(1));
			end
			else
				pre_next = pre_reg + 32'h1;
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pre_reg <= 32'h0;
			cnt_reg <= '0;
			done_reg <= 1'b0;
		end
		else
		begin
			pre_reg <= pre_next;
			cnt_reg <= cnt_next;
			done_reg <= done_next;
		end
	end

	assign count = cnt_reg;
	assign done = done_reg;
endmodule : second_counter
`default_nettype wire

// *** design/volt_stats.sv ***
// running average and variance of magnet voltage
`include "magnet_seq_map.svh"
`default_nettype none
module volt_stats (
	input wire logic core_clk,
	input wire logic resetn,
	volt_stats_if.producer st
);
	logic signed [31:0] avg_reg, avg_next;
	logic [47:0] var_reg, var_next;
	logic signed [32:0] diff;
	logic [65:0] sq;
	logic [47:0] sqSat;

	always_comb
	begin
		diff = 33'(st.sample) - 33'(avg_reg);
		sq = 66'(diff * diff);
		// saturate rather than wrap on a wild sample
		sqSat = (sq[65:48] != '0) ? 48'hFFFFFFFFFFFF : sq[47:0];
		avg_next = avg_reg;
		var_next = var_reg;
		if (st.valid)
		begin
			avg_next = avg_reg + 32'(diff >>> `STAT_SHIFT);
			var_next = var_reg - (var_reg >> `STAT_SHIFT) + (sqSat >> `STAT_SHIFT);
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			avg_reg <= 32'sh0;
			var_reg <= 48'h0;
		end
		else
		begin
			avg_reg <= avg_next;
			var_reg <= var_next;
		end
	end

	assign st.average = avg_reg;
	assign st.variance = var_reg;
endmodule : volt_stats
`default_nettype wire

// *** design/magnet_ramp_switch_sequencer.sv ***
// ramp and persistent-switch sequencer for a magnet supply
//
// What this block does
// (R1) heater key when on: off, wait, zero
// (R2) heater key when off: match, then heat
// (R3) shifted heater key only flips heater
// (R4) heater on sources current; persistent indicator
// (R5) beep unless switch fully configured
// (R6) heated time delays control compensation
// (R7) cooled time before current may change
// (R8) report remaining timer seconds
// (R9) cooled when average and variance low
// (R10) leave cooled above six times limit
// (R11) extra five seconds after limits met
// (R12) report running variance during sensed transitions
// (R13) cooling gain added while cooling
// (R14) ramp commands refused during transitions
// (R15) target up to limit, never negative
// (R16) shifted target shows magnet three seconds
// (R17) show present or recorded magnet current
// (R18) ramp/pause key toggles ramping
// (R19) return_to_zero_key keeps target
// (R20) resume after paused zero goes target
// (R21) persistent zero ramps supply only
// (R22) explicit heater states drive everything
// (R23) blank ramp mode lights quench
`include "magnet_seq_map.svh"
`default_nettype none
module magnet_ramp_switch_sequencer
	import magnet_seq_pkg::*;
#(
	parameter int CUR_W = 24,
	parameter int SEC_CYCLES = `CLK_HZ,
	parameter int MS_CYCLES = `CLK_HZ / `MS_PER_S
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic rampPauseKey,
	input wire logic returnToZeroKey,
	input wire logic heaterToggleKey,
	input wire logic targetKey,
	input wire logic shiftActive,
	input wire logic anyKey,
	input wire logic defaultDisplay,
	input wire logic targetEntryValid,
	input wire logic targetEntryNegative,
	input wire logic [CUR_W-1:0] targetEntry,
	input wire logic [CUR_W-1:0] currentLimit,
	input wire logic [15:0] rampRate,
	input wire logic [15:0] switchPathRampRate,
	input wire logic switchInstalled,
	input wire logic heatCurrentSet,
	input wire logic detectMethodSet,
	input wire logic voltageMode,
	input wire logic timesSet,
	input wire logic [11:0] switchHeatTime,
	input wire logic [11:0] switchCoolTime,
	input wire logic [15:0] heatCurrentCfg,
	input wire logic [7:0] coolGainPct,
	input wire logic [31:0] varLimit,
	input wire logic signed [31:0] magnetVoltage,
	input wire logic magnetVoltageValid,
	input wire logic quenchDetect,
	output logic [CUR_W-1:0] supplySetpoint,
	output logic [15:0] heaterCurrent,
	output logic persistentLed,
	output logic quenchLed,
	output ramp_mode_type rampMode,
	output heat_state_type heaterState,
	output logic errorBeep,
	output logic errorFlag,
	output logic [CUR_W-1:0] targetValue,
	output logic [11:0] timerSeconds,
	output logic [31:0] varianceStatus,
	output logic showMagnet,
	output logic [CUR_W-1:0] magnetValue,
	output logic [7:0] extraGainPct
);
	//********************
	// statistics and counters
	//********************
	volt_stats_if st();
	assign st.sample = magnetVoltage;
	assign st.valid = magnetVoltageValid;
	volt_stats u_stats (.core_clk(core_clk), .resetn(resetn), .st(st));

	logic tLoad, tDone, sLoad, sDone;
	logic [11:0] tValue, tCount;
	second_counter #(.CYC(SEC_CYCLES), .W(12)) u_timer (.core_clk(core_clk), .resetn(resetn),
		.load(tLoad), .loadValue(tValue), .count(tCount), .done(tDone));
	// (R16) three second display
	second_counter #(.CYC(SEC_CYCLES), .W(12)) u_show (.core_clk(core_clk), .resetn(resetn),
		.load(sLoad), .loadValue(`SHOW_S), .count(), .done(sDone));

	//********************
	// cooled decision with hysteresis
	//********************
	logic cooled_reg, cooled_next;
	logic [31:0] absAvg;
	always_comb
	begin
		absAvg = st.average[31] ? 32'(-st.average) : 32'(st.average);
		cooled_next = cooled_reg;
		// (R9) average and variance low
		if (!cooled_reg && absAvg < `AVG_LIMIT_NV && st.variance < 48'(varLimit))
			cooled_next = 1'b1;
		// (R10) six times exit threshold
		else if (cooled_reg && st.variance > 48'(`VAR_HYST * 48'(varLimit)))
			cooled_next = 1'b0;
	end
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			cooled_reg <= 1'b0;
		else
			cooled_reg <= cooled_next;
	end

	//********************
	// millisecond ramp tick
	//********************
	logic [31:0] ms_reg, ms_next;
	logic msTick;
	always_comb
	begin
		msTick = (ms_reg == 32'(MS_CYCLES - 1));
		ms_next = msTick ? 32'h0 : ms_reg + 32'h1;
	end
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			ms_reg <= 32'h0;
		else
			ms_reg <= ms_next;
	end

	//********************
	// sequencer
	//********************
	heat_state_type hs_reg, hs_next;
	ramp_mode_type mode_reg, mode_next;
	logic [CUR_W-1:0] sup_reg, sup_next, rec_reg, rec_next, tgt_reg, tgt_next;
	logic [CUR_W-1:0] mag_reg, mag_next, goal, step, gap;
	logic zero_reg, zero_next, auto_reg, auto_next, match_reg, match_next;
	logic settle_reg, settle_next, beep_reg, beep_next, err_reg, err_next;
	logic show_reg, show_next, quench_reg, cfgOk, busy, met, doneTrans, inCircuit;
	logic [15:0] rate, swRate;
	logic [11:0] ht, ct;
	logic [15:0] heatCurrent_reg, heatCurrent_next;
	logic persist_reg, persist_next;
	logic [11:0] timer_reg, timer_next;
	logic [31:0] varStat_reg, varStat_next;
	logic [7:0] gain_reg, gain_next;

	always_comb
	begin
		hs_next = hs_reg;
		mode_next = mode_reg;
		sup_next = sup_reg;
		rec_next = rec_reg;
		tgt_next = tgt_reg;
		zero_next = zero_reg;
		auto_next = auto_reg;
		match_next = match_reg;
		settle_next = settle_reg;
		beep_next = 1'b0;
		err_next = err_reg;
		show_next = show_reg;
		tLoad = 1'b0;
		tValue = 12'h0;
		sLoad = 1'b0;
		// (R22) everything keyed off heater state
		busy = (hs_reg == HEATING) || (hs_reg == COOLING);
		inCircuit = (hs_reg == ON_HEATED) || !switchInstalled;
		// out-of-range settings fall back to defaults
		ht = (switchHeatTime < `HEAT_TIME_MIN || switchHeatTime > `HEAT_TIME_MAX)
			? `HEAT_TIME_DEFAULT : switchHeatTime;
		ct = (switchCoolTime < `COOL_TIME_MIN || switchCoolTime > `COOL_TIME_MAX)
			? `COOL_TIME_DEFAULT : switchCoolTime;
		// (R1) switch path default rate
		swRate = (switchPathRampRate == 16'h0) ? `SW_RATE_DEFAULT : switchPathRampRate;
		rate = inCircuit ? rampRate : swRate;
		// (R5) configuration check
		cfgOk = switchInstalled && heatCurrentSet && detectMethodSet &&
			(voltageMode || timesSet);
		// (R9) voltage condition per direction
		met = (hs_reg == COOLING) ? cooled_reg : !cooled_reg;
		doneTrans = 1'b0;
		if (busy)
		begin
			if (!voltageMode)
				// (R6) (R7) timer expiry ends transition
				doneTrans = tDone;
			else if (!met)
				settle_next = 1'b0;
			else if (!settle_reg)
			begin
				// (R11) extra settle delay
				settle_next = 1'b1;
				tLoad = 1'b1;
				tValue = `SETTLE_S;
			end
			else
				doneTrans = tDone;
		end
		if (doneTrans)
		begin
			settle_next = 1'b0;
			hs_next = (hs_reg == HEATING) ? ON_HEATED : OFF_COOLED;
			// (R1) supply to zero after cool time
			if (hs_reg == COOLING && auto_reg)
				mode_next = RAMP_ACTIVE;
		end
		// (R21) (R19) goal selection, recorded value untouched
		goal = match_reg ? rec_reg : ((zero_reg || auto_reg) ? '0 : tgt_reg);
		gap = (sup_reg > goal) ? sup_reg - goal : goal - sup_reg;
		step = (gap > CUR_W'(rate)) ? CUR_W'(rate) : gap;
		// (R1) supply held while switch changes
		if (mode_reg == RAMP_ACTIVE && !busy)
		begin
			if (gap == '0)
			begin
				if (match_reg)
				begin
					// (R2) heater on only after match
					match_next = 1'b0;
					hs_next = HEATING;
					tLoad = !voltageMode;
					tValue = ht;
				end
				// (R1) supply parked at zero after cooling
				zero_next = zero_reg || auto_reg;
				auto_next = 1'b0;
				mode_next = RAMP_HOLD;
			end
			else if (msTick)
				sup_next = (sup_reg > goal) ? sup_reg - step : sup_reg + step;
		end
		else if (mode_reg == RAMP_HOLD && !busy && gap != '0)
			mode_next = RAMP_ACTIVE;
		// (R14) ramp commands refused while busy
		if ((rampPauseKey || returnToZeroKey) && busy)
		begin
			beep_next = 1'b1;
			err_next = 1'b1;
		end
		else if (rampPauseKey)
		begin
			// (R18) (R20) toggle, resume goes to target
			mode_next = (mode_reg == RAMP_ACTIVE) ? RAMP_PAUSED : RAMP_ACTIVE;
			zero_next = 1'b0;
		end
		else if (returnToZeroKey)
		begin
			// (R19) target kept
			zero_next = 1'b1;
			mode_next = RAMP_ACTIVE;
		end
		// (R15) target limit and sign
		if (targetEntryValid)
		begin
			if (targetEntryNegative || targetEntry > currentLimit)
			begin
				beep_next = 1'b1;
				err_next = 1'b1;
			end
			else
				tgt_next = targetEntry;
		end
		if (heaterToggleKey)
		begin
			if (!cfgOk || busy)
			begin
				// (R5) single error beep
				beep_next = 1'b1;
				err_next = 1'b1;
			end
			else if (hs_reg == ON_HEATED)
			begin
				hs_next = COOLING;
				rec_next = sup_reg;
				// (R3) shifted toggle leaves supply alone
				auto_next = !shiftActive;
				tLoad = !voltageMode;
				tValue = ct;
			end
			else if (shiftActive)
			begin
				// (R3) heater on without matching
				hs_next = HEATING;
				tLoad = !voltageMode;
				tValue = ht;
			end
			else
			begin
				// (R2) match recorded current first
				match_next = 1'b1;
				zero_next = 1'b0;
				mode_next = RAMP_ACTIVE;
			end
		end
		// (R16) any key ends display; new request wins
		if (anyKey || sDone)
			show_next = 1'b0;
		if (targetKey && shiftActive && defaultDisplay)
		begin
			show_next = 1'b1;
			sLoad = 1'b1;
		end
		// (R17) driven or recorded value
		mag_next = inCircuit ? sup_next : rec_next;
		if (quenchDetect)
			mode_next = RAMP_BLANK;
		else if (mode_reg == RAMP_BLANK)
			mode_next = RAMP_PAUSED;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			hs_reg <= OFF_COOLED;
			mode_reg <= RAMP_PAUSED;
			sup_reg <= '0;
			rec_reg <= '0;
			tgt_reg <= '0;
			mag_reg <= '0;
			zero_reg <= 1'b0;
			auto_reg <= 1'b0;
			match_reg <= 1'b0;
			settle_reg <= 1'b0;
			beep_reg <= 1'b0;
			err_reg <= 1'b0;
			show_reg <= 1'b0;
			quench_reg <= 1'b0;
			heatCurrent_reg <= 16'h0;
			persist_reg <= 1'b0;
			timer_reg <= 12'h0;
			varStat_reg <= 32'h0;
			gain_reg <= `COOL_GAIN_DEFAULT;
		end
		else
		begin
			hs_reg <= hs_next;
			mode_reg <= mode_next;
			sup_reg <= sup_next;
			rec_reg <= rec_next;
			tgt_reg <= tgt_next;
			mag_reg <= mag_next;
			zero_reg <= zero_next;
			auto_reg <= auto_next;
			match_reg <= match_next;
			settle_reg <= settle_next;
			beep_reg <= beep_next;
			err_reg <= err_next;
			show_reg <= show_next;
			// (R23) blank mode lights quench
			quench_reg <= (mode_next == RAMP_BLANK);
			heatCurrent_reg <= heatCurrent_next;
			persist_reg <= persist_next;
			timer_reg <= timer_next;
			varStat_reg <= varStat_next;
			gain_reg <= gain_next;
		end
	end

	//********************
	// registered status outputs
	//********************
	always_comb
	begin
		// (R4) heater current and persistent indicator
		heatCurrent_next = (hs_next == HEATING || hs_next == ON_HEATED) ? heatCurrentCfg : 16'h0;
		persist_next = switchInstalled && (hs_next == OFF_COOLED);
		// (R8) remaining seconds, zero once expired
		timer_next = (!voltageMode && busy) ? tCount : 12'h0;
		// (R12) variance in nV squared, saturated
		varStat_next = (voltageMode && busy)
			? ((st.variance[47:32] != '0) ? 32'hFFFFFFFF : st.variance[31:0]) : 32'h0;
		// (R13) cooling gain only while cooling
		gain_next = (hs_next == COOLING) ? coolGainPct : 8'h00;
	end

	assign supplySetpoint = sup_reg;
	assign heaterCurrent = heatCurrent_reg;
	assign persistentLed = persist_reg;
	assign quenchLed = quench_reg;
	assign rampMode = mode_reg;
	assign heaterState = hs_reg;
	assign errorBeep = beep_reg;
	assign errorFlag = err_reg;
	assign targetValue = tgt_reg;
	assign timerSeconds = timer_reg;
	assign varianceStatus = varStat_reg;
	assign showMagnet = show_reg;
	assign magnetValue = mag_reg;
	assign extraGainPct = gain_reg;
endmodule : magnet_ramp_switch_sequencer
`default_nettype wire

// *** dv/magnet_seq_assertions.sv ***
// port checker for the ramp and switch sequencer
`default_nettype none
module magnet_seq_assertions
	import magnet_seq_pkg::*;
#(
	parameter int CUR_W = 24
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic rampPauseKey,
	input wire logic returnToZeroKey,
	input wire logic heaterToggleKey,
	input wire logic targetKey,
	input wire logic shiftActive,
	input wire logic anyKey,
	input wire logic quenchDetect,
	input wire logic [15:0] heatCurrentCfg,
	input wire logic [7:0] coolGainPct,
	input wire logic [CUR_W-1:0] supplySetpoint,
	input wire logic [15:0] heaterCurrent,
	input wire logic persistentLed,
	input wire logic quenchLed,
	input wire ramp_mode_type rampMode,
	input wire heat_state_type heaterState,
	input wire logic errorBeep,
	input wire logic errorFlag,
	input wire logic showMagnet,
	input wire logic [7:0] extraGainPct
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	a_busy_refuse: assert property ((heaterState == HEATING || heaterState == COOLING) &&
		(rampPauseKey || returnToZeroKey) && !heaterToggleKey |-> ##[1:2] errorBeep ##[0:1] errorFlag)
		else $error("ramp key not refused in transition");
	a_flag_sticky: assert property (errorFlag |=> errorFlag)
		else $error("error flag dropped");
	a_persist_led: assert property (persistentLed |->
		heaterState == OFF_COOLED || $past(heaterState) == OFF_COOLED)
		else $error("persistent led outside cooled state");
	a_heater_idle: assert property (heaterState inside {OFF_COOLED, COOLING} |->
		heaterCurrent == 16'h0000) else $error("heater driven while off");
	a_heater_on: assert property (heaterState == ON_HEATED |->
		heaterCurrent == heatCurrentCfg) else $error("heater current wrong while on");
	a_quench_blank: assert property (quenchDetect |-> ##[1:2] rampMode == RAMP_BLANK)
		else $error("quench did not blank mode");
	a_quench_led: assert property (rampMode == RAMP_BLANK |-> ##[0:1] quenchLed)
		else $error("quench led dark");
	a_cool_gain: assert property (heaterState == COOLING && $past(heaterState) == COOLING
		|-> extraGainPct == coolGainPct) else $error("cooling gain missing");
	a_cool_hold: assert property (heaterState == COOLING && $past(heaterState) == COOLING
		|-> $stable(supplySetpoint)) else $error("supply moved while cooling");
	a_show_clear: assert property (anyKey && !(targetKey && shiftActive) |=> !showMagnet)
		else $error("key press left magnet display");
endmodule : magnet_seq_assertions
bind magnet_ramp_switch_sequencer magnet_seq_assertions #(.CUR_W(CUR_W)) i_chk (.core_clk,
	.resetn, .rampPauseKey, .returnToZeroKey, .heaterToggleKey, .targetKey, .shiftActive,
	.anyKey, .quenchDetect, .heatCurrentCfg, .coolGainPct, .supplySetpoint, .heaterCurrent,
	.persistentLed, .quenchLed, .rampMode, .heaterState, .errorBeep, .errorFlag, .showMagnet,
	.extraGainPct);
`default_nettype wire

// *** dv/magnet_supply_model.sv ***
// supply output stage and magnet voltage tap model
`default_nettype none
module magnet_supply_model #(
	parameter int CUR_W = 24,
	parameter int SAMPLE_CYC = 4,
	parameter int NV_PER_MA = 1000
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [CUR_W-1:0] supplySetpoint,
	input wire logic [15:0] heaterCurrent,
	output logic signed [31:0] magnetVoltage,
	output logic magnetVoltageValid
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	logic [CUR_W-1:0] lastSet;
	// coil only sees the supply slope while the switch is resistive
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt <= 0;
			lastSet <= '0;
			magnetVoltage <= 32'sh00000000;
			magnetVoltageValid <= 1'b0;
		end
		else
		begin
			magnetVoltageValid <= (cnt == SAMPLE_CYC - 1);
			cnt <= (cnt == SAMPLE_CYC - 1) ? 0 : cnt + 1;
			if (cnt == SAMPLE_CYC - 1)
			begin
				lastSet <= supplySetpoint;
				magnetVoltage <= (heaterCurrent != 16'h0000) ? ($signed({8'h00, supplySetpoint})
					- $signed({8'h00, lastSet})) * NV_PER_MA : 32'sh00000000;
			end
		end
	end
endmodule : magnet_supply_model
`default_nettype wire

// *** dv/magnet_ramp_switch_sequencer_tb_top.sv ***
// self-checking bench for the ramp and switch sequencer
`default_nettype none
module magnet_ramp_switch_sequencer_tb_top import magnet_seq_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, resetn, rampPauseKey, returnToZeroKey, heaterToggleKey, targetKey;
	logic shiftActive, anyKey, defaultDisplay, targetEntryValid, targetEntryNegative;
	logic switchInstalled, heatCurrentSet, detectMethodSet, voltageMode, timesSet;
	logic quenchDetect, magnetVoltageValid, persistentLed, quenchLed, errorBeep, errorFlag;
	logic showMagnet;
	logic [23:0] targetEntry, currentLimit, supplySetpoint, targetValue, magnetValue;
	logic [15:0] rampRate, switchPathRampRate, heatCurrentCfg, heaterCurrent;
	logic [11:0] switchHeatTime, switchCoolTime, timerSeconds;
	logic [7:0] coolGainPct, extraGainPct;
	logic [31:0] varLimit, varianceStatus;
	logic signed [31:0] magnetVoltage;
	ramp_mode_type rampMode;
	heat_state_type heaterState;
	int err_count, total_checks, beeps;
	// short second and millisecond keep the run small
	magnet_ramp_switch_sequencer #(.SEC_CYCLES(20), .MS_CYCLES(4)) i_dut (.core_clk, .resetn,
		.rampPauseKey, .returnToZeroKey, .heaterToggleKey, .targetKey, .shiftActive, .anyKey,
		.defaultDisplay, .targetEntryValid, .targetEntryNegative, .targetEntry, .currentLimit,
		.rampRate, .switchPathRampRate, .switchInstalled, .heatCurrentSet, .detectMethodSet,
		.voltageMode, .timesSet, .switchHeatTime, .switchCoolTime, .heatCurrentCfg,
		.coolGainPct, .varLimit, .magnetVoltage, .magnetVoltageValid, .quenchDetect,
		.supplySetpoint, .heaterCurrent, .persistentLed, .quenchLed, .rampMode, .heaterState,
		.errorBeep, .errorFlag, .targetValue, .timerSeconds, .varianceStatus, .showMagnet,
		.magnetValue, .extraGainPct);
	magnet_supply_model i_psu (.core_clk, .resetn, .supplySetpoint, .heaterCurrent,
		.magnetVoltage, .magnetVoltageValid);
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
		if (errorBeep === 1'b1)
			beeps <= beeps + 1;
	// ****
	// helpers
	// ****
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask : chk_val
	task automatic chk_state(input heat_state_type exp, input string what);
		chk_val({30'h0, heaterState}, {30'h0, exp}, what);
	endtask : chk_state
	task automatic press(ref logic k, input logic sh);
		k = 1'b1;
		shiftActive = sh;
		@(negedge core_clk);
		k = 1'b0;
		shiftActive = 1'b0;
	endtask : press
	task automatic wait_state(input heat_state_type s, input int lim);
		for (int i = 0; i < lim && heaterState !== s; i++)
			@(negedge core_clk);
		chk_state(s, "state wait");
	endtask : wait_state
	task automatic wait_supply(input logic [23:0] v, input int lim);
		for (int i = 0; i < lim && supplySetpoint !== v; i++)
			@(negedge core_clk);
		chk_val(supplySetpoint, v, "supply wait");
	endtask : wait_supply
	task automatic t_config;
		int b;
		chk_state(OFF_COOLED, "reset state");
		for (int i = 0; i < 4; i++)
		begin
			b = beeps;
			{switchInstalled, heatCurrentSet, detectMethodSet, timesSet} = ~(4'h8 >> i);
			press(heaterToggleKey, 1'b0);
			repeat (3) @(negedge core_clk);
			chk_val(beeps - b, 1, "config beep");
			chk_state(OFF_COOLED, "config state");
		end
		{switchInstalled, heatCurrentSet, detectMethodSet, timesSet} = 4'hF;
		$display("t_config done");
	endtask : t_config
	task automatic t_target;
		int b;
		logic [23:0] val [4] = '{24'h000005, 24'h000101, 24'h000100, 24'h000028};
		logic [23:0] exp [4] = '{24'h000000, 24'h000000, 24'h000100, 24'h000028};
		for (int i = 0; i < 4; i++)
		begin
			b = beeps;
			targetEntry = val[i];
			targetEntryNegative = (i == 0);
			press(targetEntryValid, 1'b0);
			repeat (2) @(negedge core_clk);
			chk_val(beeps - b, (i < 2), "entry beep");
			chk_val(targetValue, exp[i], "target");
		end
		$display("t_target done");
	endtask : t_target
	task automatic t_heat;
		int b;
		// mid-run reset clears the sticky flag
		resetn = 1'b0;
		@(negedge core_clk);
		resetn = 1'b1;
		press(targetEntryValid, 1'b0);
		@(negedge core_clk);
		press(heaterToggleKey, 1'b0);
		wait_state(HEATING, 20);
		chk_val(errorFlag, 0, "flag before");
		b = beeps;
		press(rampPauseKey, 1'b0);
		repeat (2) @(negedge core_clk);
		chk_val(beeps - b, 1, "busy beep");
		chk_val(errorFlag, 1, "busy flag");
		repeat (85) @(negedge core_clk);
		chk_state(HEATING, "heat time");
		wait_state(ON_HEATED, 40);
		chk_val(heaterCurrent, 16'h0123, "heater drive");
		chk_val(persistentLed, 0, "driven led");
		$display("t_heat done");
	endtask : t_heat
	task automatic t_ramp;
		logic [23:0] s;
		press(rampPauseKey, 1'b0);
		repeat (6) @(negedge core_clk);
		press(rampPauseKey, 1'b0);
		@(negedge core_clk);
		s = supplySetpoint;
		repeat (12) @(negedge core_clk);
		chk_val(supplySetpoint, s, "paused hold");
		chk_val({30'h0, rampMode}, {30'h0, RAMP_PAUSED}, "paused");
		press(rampPauseKey, 1'b0);
		wait_supply(24'h000028, 40);
		press(returnToZeroKey, 1'b0);
		repeat (10) @(negedge core_clk);
		chk_val(supplySetpoint < 24'h000028, 1, "zeroing");
		chk_val(targetValue, 24'h000028, "target kept");
		press(rampPauseKey, 1'b0);
		@(negedge core_clk);
		press(rampPauseKey, 1'b0);
		wait_supply(24'h000028, 40);
		chk_val(magnetValue, 24'h000028, "driven value");
		$display("t_ramp done");
	endtask : t_ramp
	task automatic t_cool;
		press(heaterToggleKey, 1'b0);
		@(negedge core_clk);
		chk_state(COOLING, "cooling");
		chk_val(timerSeconds inside {[1:5]}, 1, "countdown");
		chk_val(extraGainPct, 8'h19, "cool gain");
		chk_val(varianceStatus, 0, "no variance in timer");
		repeat (90) @(negedge core_clk);
		chk_val(supplySetpoint, 24'h000028, "held while cooling");
		wait_state(OFF_COOLED, 40);
		chk_val(timerSeconds, 0, "timer expired");
		for (int i = 0; i < 20 && supplySetpoint === 24'h000028; i++)
			@(negedge core_clk);
		chk_val(supplySetpoint, 24'h00001E, "path step");
		wait_supply(24'h000000, 40);
		chk_val(persistentLed, 1, "persistent led");
		repeat (20) @(negedge core_clk);
		chk_val(supplySetpoint, 0, "parked at zero");
		$display("t_cool done");
	endtask : t_cool
	task automatic t_show;
		press(targetKey, 1'b1);
		@(negedge core_clk);
		chk_val(showMagnet, 0, "show off default");
		defaultDisplay = 1'b1;
		press(targetKey, 1'b1);
		repeat (40) @(negedge core_clk);
		chk_val(showMagnet, 1, "magnet shown");
		chk_val(magnetValue, 24'h000028, "recorded current");
		press(anyKey, 1'b0);
		@(negedge core_clk);
		chk_val(showMagnet, 0, "key clears");
		press(returnToZeroKey, 1'b0);
		@(negedge core_clk);
		press(targetKey, 1'b1);
		repeat (2) @(negedge core_clk);
		chk_val(magnetValue, 24'h000028, "persistent kept");
		repeat (70) @(negedge core_clk);
		chk_val(showMagnet, 0, "show expired");
		$display("t_show done");
	endtask : t_show
	task automatic t_flip;
		press(heaterToggleKey, 1'b0);
		repeat (6) @(negedge core_clk);
		chk_state(OFF_COOLED, "match first");
		wait_supply(24'h000028, 40);
		wait_state(ON_HEATED, 150);
		// ramp variance must die away before sensing
		repeat (700) @(negedge core_clk);
		voltageMode = 1'b1;
		press(heaterToggleKey, 1'b1);
		repeat (60) @(negedge core_clk);
		chk_state(COOLING, "settle delay");
		chk_val(varianceStatus < varLimit, 1, "variance shown");
		wait_state(OFF_COOLED, 300);
		chk_val(supplySetpoint, 24'h000028, "supply untouched");
		quenchDetect = 1'b1;
		repeat (3) @(negedge core_clk);
		chk_val(quenchLed, 1, "quench led");
		$display("t_flip done");
	endtask : t_flip
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	initial
	begin
		{resetn, rampPauseKey, returnToZeroKey, heaterToggleKey, targetKey, shiftActive} = '0;
		{anyKey, defaultDisplay, targetEntryValid, targetEntryNegative, voltageMode} = '0;
		{quenchDetect, targetEntry, switchPathRampRate} = '0;
		{switchInstalled, heatCurrentSet, detectMethodSet, timesSet} = 4'hF;
		currentLimit = 24'h000100;
		rampRate = 16'h0008;
		switchHeatTime = 12'h005;
		switchCoolTime = 12'h005;
		heatCurrentCfg = 16'h0123;
		coolGainPct = 8'h19;
		varLimit = 32'h00000064;
		repeat (2) @(negedge core_clk);
		resetn = 1'b1;
		t_config;
		t_target;
		t_heat;
		t_ramp;
		t_cool;
		t_show;
		t_flip;
		results;
	end
	// whole run needs about fourteen hundred cycles
	initial
	begin
		repeat (6000) @(posedge core_clk);
		err_count++;
		$display("CHECK FAILED at %0t: watchdog", $time);
		results;
	end
endmodule : magnet_ramp_switch_sequencer_tb_top
`default_nettype wire
